// *** logic/imst_pkg.sv ***
// Package with constants and carrier types for the two-wire master start and transmit block.
package imst_pkg;

  // ****************************************
  // Widths and positions
  // ****************************************
  localparam int unsigned BRG_W          = 12;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned CTRL_ON_BIT    = 15;
  localparam int unsigned CTRL_BEGIN_BIT = 0;
  localparam int unsigned CTRL_LOW_W     = 5;
  localparam int unsigned STAT_ACK_BIT   = 15;
  localparam int unsigned STAT_STOP_BIT  = 4;
  localparam int unsigned STAT_START_BIT = 3;
  localparam int unsigned STAT_FULL_BIT  = 0;

  // ****************************************
  // Counts and reset values
  // ****************************************
  localparam logic [3:0]       DATA_BITS      = 4'h8;
  localparam logic [3:0]       ACK_CLOCK      = 4'h9;
  localparam logic [BRG_W-1:0] BRG_MIN_LEGAL  = 12'h002;
  localparam logic [15:0]      CTRL_RESET     = 16'h0000;
  localparam logic [15:0]      STAT_RESET     = 16'h0010;
  localparam logic [7:0]       TX_RESET       = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    IMST_IDLE   = 3'b000,
    IMST_ST_A   = 3'b001,
    IMST_ST_B   = 3'b010,
    IMST_TX_LOW = 3'b011,
    IMST_TX_HI  = 3'b100
  } imst_state_t;

  typedef struct packed {
    logic sda_o;
    logic sda_oe;
    logic scl_o;
    logic scl_oe;
  } imst_pins_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] data;
  } imst_tx_wr_t;

endpackage : imst_pkg

// *** logic/imst_brg.sv ***
// Reload-based bit rate countdown timer.
`timescale 1ns/1ps
module imst_brg (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Control
  input  wire logic                     load,
  input  wire logic [imst_pkg::BRG_W-1:0] reload,
  // Status
  output logic                          timeout
);

  logic [imst_pkg::BRG_W-1:0] count_reg;
  logic                       run_reg;

  // ****************************************
  // Countdown
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_reg <= '0;
      run_reg   <= 1'b0;
      timeout   <= 1'b0;
    end
    else if (load)
    begin
      count_reg <= (reload < imst_pkg::BRG_MIN_LEGAL) ? imst_pkg::BRG_MIN_LEGAL : reload; // [R23]
      run_reg   <= 1'b1;
      timeout   <= 1'b0;
    end
    else if (run_reg)
    begin
      count_reg <= count_reg - 1'b1;
      timeout   <= (count_reg == {{(imst_pkg::BRG_W-1){1'b0}}, 1'b1});
      run_reg   <= (count_reg != {{(imst_pkg::BRG_W-1){1'b0}}, 1'b1}); // [R23]
    end
    else
    begin
      timeout <= 1'b0;
    end
  end

endmodule : imst_brg

// *** logic/imst_master.sv ***
// Master start generator and byte transmitter for a two-wire serial bus.
`timescale 1ns/1ps
// Overview of operation
// R1: Software sets enable bit before master operations.
// R2: Device performs single protocol pieces only.
// R3: Software starts step, waits interrupt or polls.
// R4: No queueing; busy transmit write sets collision.
// R5: Control bit 0 requests a start.
// R6: Software checks stop-detected bit before start.
// R7: Start request begins countdown, lines released.
// R8: First timeout pulls data low, restarts countdown.
// R9: Second timeout pulls clock low, interrupts, clears.
// R10: Detected start sets start bit, clears stop.
// R11: After start both lines held low.
// R12: Low five control bits ignore writes during start.
// R13: Transmit write begins send, sets full bit.
// R14: Eight bits, data changes after falling clock.
// R15: Eighth fall clears full, releases data, ninth clock.
// R16: Acknowledge latched on ninth falling edge.
// R17: Ack result zero when low, one when high.
// R18: After ninth clock interrupt, then stay idle.
// R19: Bytes sent exactly as written, unchecked.
// R20: Seven-bit address is one byte plus direction.
// R21: Ten-bit address sent as two bytes.
// R22: Ten-bit read needs repeated start, direction one.
// R23: Timer counts reload to zero; 0 and 1 forbidden.
// R24: Interrupt is pulse of at least one cycle.
module imst_master (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Control word write port
  input  wire logic                         ctrl_wr,
  input  wire logic [15:0]                  ctrl_wdata,
  // Transmit holding register write port
  input  wire imst_pkg::imst_tx_wr_t        tx_wr,
  // Software clear of the collision flag
  input  wire logic                         collision_clr,
  // Bit rate reload value
  input  wire logic [imst_pkg::BRG_W-1:0]   bit_rate_reload,
  // Bus pins
  input  wire logic                         serial_clock_pin_i,
  input  wire logic                         serial_data_pin_i,
  output imst_pkg::imst_pins_t              pins,
  // Status and event outputs
  output logic [15:0]                       control_word,
  output logic [15:0]                       status_word,
  output logic [7:0]                        tx_holding_reg,
  output logic                              write_collision_flag,
  output logic                              master_event_irq
);

  imst_pkg::imst_state_t state_reg;
  logic [3:0]            bit_cnt_reg;
  logic                  brg_load;
  logic                  brg_timeout;
  logic                  scl_s1_reg;
  logic                  scl_s2_reg;
  logic                  sda_s1_reg;
  logic                  sda_s2_reg;
  logic                  scl_d_reg;
  logic                  sda_d_reg;
  logic                  start_seen;
  logic                  stop_seen;
  logic                  busy;
  logic                  enabled;
  logic                  tx_accept;
  logic                  start_req;
  logic                  tx_fall;
  logic                  next_oe_reg;
  logic                  data_due_reg;

  assign enabled    = control_word[imst_pkg::CTRL_ON_BIT];
  assign busy       = (state_reg != imst_pkg::IMST_IDLE);
  assign tx_accept  = tx_wr.wr && !busy && enabled;
  assign start_req  = ctrl_wr && ctrl_wdata[imst_pkg::CTRL_BEGIN_BIT] && !busy
                      && ctrl_wdata[imst_pkg::CTRL_ON_BIT];
  assign start_seen = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
  assign stop_seen  = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;
  assign tx_fall    = (state_reg == imst_pkg::IMST_TX_HI) && brg_timeout
                      && scl_s2_reg && scl_d_reg;

  // ****************************************
  // Bit rate timer
  // ****************************************
  imst_brg u_brg (
    .clk     (clk),
    .rst_n   (rst_n),
    .load    (brg_load),
    .reload  (bit_rate_reload),
    .timeout (brg_timeout)
  );

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      scl_d_reg  <= 1'b1;
      sda_d_reg  <= 1'b1;
    end
    else
    begin
      scl_s1_reg <= serial_clock_pin_i;
      scl_s2_reg <= scl_s1_reg;
      sda_s1_reg <= serial_data_pin_i;
      sda_s2_reg <= sda_s1_reg;
      scl_d_reg  <= scl_s2_reg;
      sda_d_reg  <= sda_s2_reg;
    end
  end

  // ****************************************
  // Control word
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      control_word <= imst_pkg::CTRL_RESET;
    end
    else
    begin
      if (ctrl_wr)
      begin
        control_word[15:imst_pkg::CTRL_LOW_W] <= ctrl_wdata[15:imst_pkg::CTRL_LOW_W];
        if (!busy)
        begin
          control_word[imst_pkg::CTRL_LOW_W-1:0] <= ctrl_wdata[imst_pkg::CTRL_LOW_W-1:0]; // [R12]
        end
      end
      if (state_reg == imst_pkg::IMST_ST_B && brg_timeout)
      begin
        control_word[imst_pkg::CTRL_BEGIN_BIT] <= 1'b0; // [R9]
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg   <= imst_pkg::IMST_IDLE;
      bit_cnt_reg <= 4'h0;
      brg_load    <= 1'b0;
      pins        <= '0;
    end
    else
    begin
      brg_load <= 1'b0;
      if (data_due_reg)
      begin
        pins.sda_oe <= next_oe_reg; // [R14]
      end
      unique case (state_reg)
        imst_pkg::IMST_IDLE:
        begin
          if (start_req)
          begin
            state_reg   <= imst_pkg::IMST_ST_A; // [R5]
            brg_load    <= 1'b1;                // [R7]
            pins.sda_oe <= 1'b0;
            pins.scl_oe <= 1'b0;
          end
          else if (tx_accept)
          begin
            state_reg   <= imst_pkg::IMST_TX_LOW; // [R13]
            bit_cnt_reg <= 4'h0;
            brg_load    <= 1'b1;
            pins.sda_o  <= 1'b0;
            pins.sda_oe <= !tx_wr.data[7]; // [R14]
            pins.scl_oe <= 1'b1;
          end
        end
        imst_pkg::IMST_ST_A:
        begin
          if (brg_timeout)
          begin
            state_reg   <= imst_pkg::IMST_ST_B;
            pins.sda_oe <= 1'b1; // [R8]
            brg_load    <= 1'b1; // [R8]
          end
        end
        imst_pkg::IMST_ST_B:
        begin
          if (brg_timeout)
          begin
            state_reg   <= imst_pkg::IMST_IDLE; // [R2]
            pins.scl_oe <= 1'b1; // [R9] [R11]
          end
        end
        imst_pkg::IMST_TX_LOW:
        begin
          if (brg_timeout)
          begin
            state_reg   <= imst_pkg::IMST_TX_HI;
            pins.scl_oe <= 1'b0;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        imst_pkg::IMST_TX_HI:
        begin
          if (!scl_s2_reg)
          begin
            brg_load <= 1'b0;
          end
          else if (scl_s2_reg && !scl_d_reg)
          begin
            brg_load <= 1'b1;
          end
          else if (brg_timeout)
          begin
            pins.scl_oe <= 1'b1;
            if (bit_cnt_reg == imst_pkg::ACK_CLOCK)
            begin
              state_reg   <= imst_pkg::IMST_IDLE; // [R18]
            end
            else
            begin
              state_reg   <= imst_pkg::IMST_TX_LOW;
              brg_load    <= 1'b1;
            end
          end
        end
        default:
        begin
          state_reg <= imst_pkg::IMST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Data bit launch
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      next_oe_reg  <= 1'b0;
      data_due_reg <= 1'b0;
    end
    else
    begin
      data_due_reg <= tx_fall; // [R14]
      if (tx_fall)
      begin
        if (bit_cnt_reg == imst_pkg::ACK_CLOCK)
        begin
          next_oe_reg <= 1'b1;
        end
        else if (bit_cnt_reg == imst_pkg::DATA_BITS)
        begin
          next_oe_reg <= 1'b0; // [R15]
        end
        else
        begin
          next_oe_reg <= !tx_holding_reg[3'(7 - bit_cnt_reg)]; // [R14] [R19]
        end
      end
    end
  end

  // ****************************************
  // Transmit holding register and collision
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_holding_reg       <= imst_pkg::TX_RESET;
      write_collision_flag <= 1'b0;
    end
    else
    begin
      if (tx_accept)
      begin
        tx_holding_reg <= tx_wr.data; // [R19]
      end
      if (tx_wr.wr && busy)
      begin
        write_collision_flag <= 1'b1; // [R4]
      end
      else if (collision_clr)
      begin
        write_collision_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // Status word and interrupt
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      status_word      <= imst_pkg::STAT_RESET;
      master_event_irq <= 1'b0;
    end
    else
    begin
      master_event_irq <= 1'b0;
      if (start_seen)
      begin
        status_word[imst_pkg::STAT_START_BIT] <= 1'b1; // [R10]
        status_word[imst_pkg::STAT_STOP_BIT]  <= 1'b0; // [R10]
      end
      else if (stop_seen)
      begin
        status_word[imst_pkg::STAT_START_BIT] <= 1'b0;
        status_word[imst_pkg::STAT_STOP_BIT]  <= 1'b1;
      end
      if (tx_accept)
      begin
        status_word[imst_pkg::STAT_FULL_BIT] <= 1'b1; // [R13]
      end
      if (tx_fall)
      begin
        if (bit_cnt_reg == imst_pkg::DATA_BITS)
        begin
          status_word[imst_pkg::STAT_FULL_BIT] <= 1'b0; // [R15]
        end
        if (bit_cnt_reg == imst_pkg::ACK_CLOCK)
        begin
          status_word[imst_pkg::STAT_ACK_BIT] <= sda_s2_reg; // [R16] [R17]
          master_event_irq                    <= 1'b1;       // [R18] [R24]
        end
      end
      if (state_reg == imst_pkg::IMST_ST_B && brg_timeout)
      begin
        master_event_irq <= 1'b1; // [R9] [R24]
      end
    end
  end

endmodule : imst_master

// *** verification/imst_master_sva.sv ***
// Port checker of the start and transmit block.
`timescale 1ns/1ps
module imst_master_sva (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst_n,
  // Watched ports
  input wire imst_pkg::imst_tx_wr_t tx_wr,
  input wire imst_pkg::imst_pins_t  pins,
  input wire logic [15:0]           control_word,
  input wire logic [15:0]           status_word,
  input wire logic [7:0]            tx_holding_reg,
  input wire logic                  write_collision_flag,
  input wire logic                  master_event_irq
);
  // **********
  // Properties
  // **********
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_START_IDLE: assert property (
    $rose(control_word[0]) |-> !pins.sda_oe [*3])
    else $error("Start drove data too soon");
  AST_DATA_FIRST: assert property (
    control_word[0] && pins.scl_oe |-> pins.sda_oe)
    else $error("Start drove clock before data");
  AST_START_DONE: assert property (
    $fell(control_word[0]) |-> pins.scl_oe && pins.sda_oe
      && (master_event_irq || $past(master_event_irq)))
    else $error("Start ended without low lines and event");
  AST_START_SEEN: assert property (
    $rose(status_word[3]) |-> !status_word[4])
    else $error("Start seen while stop still set");
  AST_FULL_CAUSE: assert property (
    $rose(status_word[0]) |-> $past(tx_wr.wr))
    else $error("Full bit set without a write");
  AST_NO_QUEUE: assert property (
    tx_wr.wr && (status_word[0] || control_word[0])
      |=> write_collision_flag && $stable(tx_holding_reg))
    else $error("Busy write was not refused");
  AST_BIT_ON_LOW: assert property (
    $changed(pins.sda_oe) && (status_word[0] || $past(status_word[0]))
      |-> pins.scl_oe && $past(pins.scl_oe))
    else $error("Data changed while clock released");
  AST_FULL_RELEASE: assert property (
    $fell(status_word[0]) |-> pins.scl_oe ##1 !pins.sda_oe)
    else $error("Data not released at end of byte");
  AST_IRQ_PULSE: assert property (
    master_event_irq |-> pins.scl_oe ##1 !master_event_irq)
    else $error("Event pulse malformed");
  AST_ACK_AT_END: assert property (
    $changed(status_word[15]) |-> ##[0:4] master_event_irq)
    else $error("Ack result changed outside ninth clock");
  cover property (master_event_irq && status_word[15]);
  cover property (master_event_irq && !status_word[15]);
  cover property ($rose(write_collision_flag));
endmodule : imst_master_sva

// *** verification/imst_slave_model.sv ***
// Bus slave model that acknowledges bytes and may stretch the clock.
`timescale 1ns/1ps
module imst_slave_model (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Bus levels and behaviour
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       nack,
  input wire logic [3:0] stretch,
  // Drives and captured byte
  output logic           scl_oe,
  output logic           sda_oe,
  output logic [7:0]     rx_byte,
  output logic           rx_valid
);
  // **********
  // Bus side
  // **********
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_cnt;
  logic [3:0] hold;
  always @(posedge clk)
  begin
    scl_q <= scl;
    sda_q <= sda;
    rx_valid <= 1'b0;
    if (!rst_n)
      {bit_cnt, hold, scl_oe, sda_oe, rx_byte} <= '0;
    else if (scl && scl_q && sda_q && !sda)
      bit_cnt <= 4'h0;
    else if (scl && !scl_q)
    begin
      bit_cnt <= bit_cnt + 4'h1;
      rx_byte <= (bit_cnt < 4'h8) ? {rx_byte[6:0], sda} : rx_byte;
      rx_valid <= (bit_cnt == 4'h7);
    end
    else if (!scl && scl_q)
    begin
      sda_oe <= (bit_cnt == 4'h8) && !nack;
      bit_cnt <= (bit_cnt == 4'h9) ? 4'h0 : bit_cnt;
      scl_oe <= (stretch != 4'h0);
      hold <= stretch;
    end
    else if (hold != 4'h0)
    begin
      hold <= hold - 4'h1;
      scl_oe <= (hold != 4'h1);
    end
  end
endmodule : imst_slave_model

// *** verification/imst_master_bench.sv ***
// Self-checking bench of the start and transmit block.
`timescale 1ns/1ps
module imst_master_bench;
  // **********
  // Bench
  // **********
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  ctrl_wr = 1'b0;
  logic [15:0]           ctrl_wdata = 16'h0000;
  imst_pkg::imst_tx_wr_t tx_wr = '0;
  logic                  collision_clr = 1'b0;
  logic [11:0]           bit_rate_reload = 12'h008;
  logic                  nack = 1'b0;
  logic [3:0]            stretch = 4'h0;
  imst_pkg::imst_pins_t  pins;
  logic [15:0]           control_word;
  logic [15:0]           status_word;
  logic [7:0]            tx_holding_reg;
  logic                  write_collision_flag;
  logic                  master_event_irq;
  logic                  s_scl_oe;
  logic                  s_sda_oe;
  logic [7:0]            rx_byte;
  logic                  rx_valid;
  logic [7:0]            b;
  logic [7:0]            exp_q[$];
  wire logic             serial_clock_pin_i = !(pins.scl_oe || s_scl_oe);
  wire logic             serial_data_pin_i = !(pins.sda_oe || s_sda_oe);
  int                    miscompares = 0;
  int                    tests_run = 0;
  int                    seed = 32'h891D5EFF;
  always #5 clk = !clk;
  imst_master i_imst_master (
    .clk                  (clk),
    .rst_n                (rst_n),
    .ctrl_wr              (ctrl_wr),
    .ctrl_wdata           (ctrl_wdata),
    .tx_wr                (tx_wr),
    .collision_clr        (collision_clr),
    .bit_rate_reload      (bit_rate_reload),
    .serial_clock_pin_i   (serial_clock_pin_i),
    .serial_data_pin_i    (serial_data_pin_i),
    .pins                 (pins),
    .control_word         (control_word),
    .status_word          (status_word),
    .tx_holding_reg       (tx_holding_reg),
    .write_collision_flag (write_collision_flag),
    .master_event_irq     (master_event_irq)
  );
  imst_slave_model i_imst_slave_model (.clk(clk), .rst_n(rst_n), .scl(serial_clock_pin_i),
    .sda(serial_data_pin_i), .nack(nack), .stretch(stretch), .scl_oe(s_scl_oe),
    .sda_oe(s_sda_oe), .rx_byte(rx_byte), .rx_valid(rx_valid));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic wait_irq;
    int i;
    for (i = 0; i < 1000 && master_event_irq !== 1'b1; i++)
      step();
    if (i == 1000)
    begin
      miscompares++;
      finish_test();
    end
  endtask : wait_irq
  task automatic collide(input logic [7:0] v);
    tx_wr = '{1'b1, v};
    step();
    tx_wr.wr = 1'b0;
    step();
    check(write_collision_flag, 1'b1);
    collision_clr = 1'b1;
    step();
    collision_clr = 1'b0;
    check(write_collision_flag, 1'b0);
  endtask : collide
  task automatic send(input logic [7:0] v);
    exp_q.push_back(v);
    tx_wr = '{1'b1, v};
    step();
    tx_wr.wr = 1'b0;
    check(status_word[0], 1'b1);
    step(3);
    collide(~v);
    check(tx_holding_reg, v);
    wait_irq();
    check(status_word[0], 1'b0);
    check(status_word[15], nack);
    step();
  endtask : send
  always @(posedge clk)
    if (rx_valid === 1'b1)
      check(rx_byte, exp_q.pop_front());
  initial
  begin
    step(12);
    rst_n = 1'b1;
    check(control_word, imst_pkg::CTRL_RESET);
    check(pins, 4'h0);
    check(status_word, imst_pkg::STAT_RESET);
    ctrl_wdata = 16'h8001;
    ctrl_wr = 1'b1;
    step();
    ctrl_wdata = 16'h8000;
    step();
    ctrl_wr = 1'b0;
    check(control_word, 16'h8001);
    collide(8'h5A);
    wait_irq();
    check(control_word, 16'h8000);
    check({status_word[4:3], pins.sda_oe, pins.scl_oe}, 16'h0007);
    $display("Start test done");
    for (int i = 0; i < 8; i++)
    begin
      b = (i == 0) ? 8'hA0 : (i == 1) ? 8'hF2 : (i == 2) ? 8'h3C : 8'($random(seed));
      nack = 1'($random(seed));
      stretch = 4'($random(seed));
      send(b);
    end
    nack = 1'b0;
    stretch = 4'h0;
    step(16);
    ctrl_wdata = 16'h8001;
    ctrl_wr = 1'b1;
    step();
    ctrl_wr = 1'b0;
    wait_irq();
    check(control_word, 16'h8000);
    check({status_word[4:3], pins.sda_oe, pins.scl_oe}, 16'h0007);
    send(8'hF3);
    $display("Repeated start test done");
    step(4);
    check(exp_q.size(), 16'h0000);
    $display("Transmit test done");
    finish_test();
  end
endmodule : imst_master_bench
bind imst_master imst_master_sva i_imst_master_sva (
  .clk                  (clk),
  .rst_n                (rst_n),
  .tx_wr                (tx_wr),
  .pins                 (pins),
  .control_word         (control_word),
  .status_word          (status_word),
  .tx_holding_reg       (tx_holding_reg),
  .write_collision_flag (write_collision_flag),
  .master_event_irq     (master_event_irq)
);
